// ===== verilog/rx_err_pkg.sv
// Constants for the receive channel with per-entry error flags.
// Assumes a single 200 MHz clock and a plain strobe register port.
//
// Notes on behaviour
// R1: Every FIFO entry stores a framing error bit, set when stop bit missing.
// R2: Framing error flag is read-only, shows only the oldest entry.
// R3: A framing error does not stop reception of later characters.
// R4: Reading the receive buffer advances the FIFO; flags follow new head.
// R5: Clearing the on bit empties the FIFO and clears the framing flag.
// R6: Framing error at head with its enable raises the summary error.
// R7: Framing error at head with its enable hides the receive flag.
// R8: Mode 0011 checks even parity, 0010 odd; eight data plus parity bit.
// R9: Parity error flag shows check result of the head entry.
// R10: Parity error at head with its enable raises the summary error.
// R11: Parity error at head with its enable hides the receive flag.
// R12: A character completing into a full FIFO sets overflow and is dropped.
// R13: Overflow with run-on set keeps framing the line, drops every character.
// R14: Overflow with run-on clear stops the shifter, ignoring the line.
// R15: Overflow ends by reading the buffer and clearing the flag in software.
// R16: Overflow with its enable raises the summary error.
// R17: Receive flag is set per character into the FIFO; interrupt needs enable.
// R18: Polarity invert flips the line before start, data and stop detection.
// R19: Software configures baud, pin, mode, polarity, on, interrupts, then enable.
// R20: Software reads the error flags before reading the received byte.
// R21: FIFO depth is at least two entries of data plus two error bits.
// R22: Reset empties the FIFO and clears all flags.
package rx_err_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_CTRL2 = 4'h1;
   localparam logic [3:0] ADDR_BAUD_LOW = 4'h2;
   localparam logic [3:0] ADDR_BAUD_HIGH = 4'h3;
   localparam logic [3:0] ADDR_ERR_FLAG = 4'h4;
   localparam logic [3:0] ADDR_ERR_IE = 4'h5;
   localparam logic [3:0] ADDR_RX_BUF = 4'h6;
   localparam logic [3:0] ADDR_INT = 4'h7;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   // Control: mode [3:0], receiver_enable 4, on 7
   localparam int CTRL_RECEIVER_ENABLE_BIT = 4;
   localparam int CTRL_ON_BIT = 7;
   // Control two: polarity invert 2, run_on_overflow 7
   localparam int CTRL2_POL_BIT = 2;
   localparam int CTRL2_RUN_ON_OVERFLOW_BIT = 7;
   // Error flag and enable registers: overflow 1, framing 2, parity 3
   localparam int ERR_OVF_BIT = 1;
   localparam int ERR_FRM_BIT = 2;
   localparam int ERR_PAR_BIT = 3;
   // Interrupt register: receive flag 0, receive enable 1, summary 2
   localparam int INT_RXF_BIT = 0;
   localparam int INT_RXE_BIT = 1;
   // ---------------------------------------------------------------
   // Modes and reset values
   // ---------------------------------------------------------------
   localparam logic [3:0] MODE_ODD = 4'h2;
   localparam logic [3:0] MODE_EVEN = 4'h3;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] BAUD_RESET = 16'h0000;
   localparam int FIFO_DEPTH = 2;
   localparam int PTR_W = 1;
   localparam logic [PTR_W:0] FIFO_FULL_CNT = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_DATA = 3'b010,
      ST_PARITY = 3'b011,
      ST_STOP = 3'b100
   } rx_state_t;
endpackage : rx_err_pkg

// ===== verilog/uart_rx_error_fifo.sv
// Receive shifter, error-tagged FIFO and register port.
// Assumes the line is asynchronous; it is synchronised here. One bit time is
// (baud divisor + 1) clocks; sampling at mid-bit.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_error_fifo (
   input wire logic CORE_CLK_IN,
   input wire logic RST_IN,
   input wire logic RX_LINE_IN,
   input wire logic [3:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [7:0] RDATA_OUT,
   output logic RX_IRQ_OUT,
   output logic ERR_IRQ_OUT
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   localparam int FIFO_DEPTH = rx_err_pkg::FIFO_DEPTH;

   logic [7:0] ctrl_ff;
   logic [7:0] ctrl2_ff;
   logic [15:0] baud_ff;
   logic [3:0] err_ie_ff;
   logic rx_int_en_ff;
   logic ovf_ff;
   logic rxf_ff;
   logic sync1_ff;
   logic sync2_ff;
   logic [9:0] mem_ff [FIFO_DEPTH]; // see R21
   logic [rx_err_pkg::PTR_W-1:0] wptr_ff;
   logic [rx_err_pkg::PTR_W-1:0] rptr_ff;
   logic [rx_err_pkg::PTR_W:0] cnt_ff;
   rx_err_pkg::rx_state_t state_ff;
   logic [15:0] tick_ff;
   logic [2:0] bit_ff;
   logic [7:0] shift_ff;
   logic par_bit_ff;

   wire logic on_w = ctrl_ff[rx_err_pkg::CTRL_ON_BIT];
   wire logic receiver_enable_w = ctrl_ff[rx_err_pkg::CTRL_RECEIVER_ENABLE_BIT];
   wire logic [3:0] mode_w = ctrl_ff[3:0];
   wire logic run_on_overflow_w = ctrl2_ff[rx_err_pkg::CTRL2_RUN_ON_OVERFLOW_BIT];
   wire logic line_w = sync2_ff ^ ctrl2_ff[rx_err_pkg::CTRL2_POL_BIT]; // see R18
   wire logic par_mode_w = (mode_w == rx_err_pkg::MODE_EVEN) ||
                           (mode_w == rx_err_pkg::MODE_ODD); // see R8
   wire logic empty_w = (cnt_ff == '0);
   wire logic full_w = (cnt_ff == rx_err_pkg::FIFO_FULL_CNT);
   wire logic [9:0] head_w = mem_ff[rptr_ff];
   wire logic head_frm_w = !empty_w && head_w[8]; // see R2
   wire logic head_par_w = !empty_w && head_w[9]; // see R9
   wire logic buf_rd_w = RD_IN && (ADDR_IN == rx_err_pkg::ADDR_RX_BUF);
   wire logic pop_w = buf_rd_w && !empty_w; // see R4
   wire logic mid_w = (tick_ff == {1'b0, baud_ff[15:1]});
   wire logic end_w = (tick_ff == baud_ff);
   // Shifter halts in overflow unless run-on is chosen
   wire logic run_w = on_w && receiver_enable_w && !(ovf_ff && !run_on_overflow_w); // see R14
   wire logic done_w = (state_ff == rx_err_pkg::ST_STOP) && end_w;
   wire logic par_ok_w = ((^shift_ff) ^ par_bit_ff) ==
                         (mode_w == rx_err_pkg::MODE_ODD); // see R8
   // Every completion during overflow is dropped, full or not
   wire logic push_w = done_w && !full_w && !ovf_ff; // see R13
   wire logic drop_w = done_w && (full_w || ovf_ff); // see R12
   wire logic frm_hide_w = err_ie_ff[rx_err_pkg::ERR_FRM_BIT] && head_frm_w; // see R7
   wire logic par_hide_w = err_ie_ff[rx_err_pkg::ERR_PAR_BIT] && head_par_w; // see R11

   // ---------------------------------------------------------------
   // Line synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
      end else begin
         sync1_ff <= RX_LINE_IN;
         sync2_ff <= sync1_ff;
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         ctrl_ff <= rx_err_pkg::CTRL_RESET;
         ctrl2_ff <= rx_err_pkg::CTRL_RESET;
         baud_ff <= rx_err_pkg::BAUD_RESET;
         err_ie_ff <= 4'h0;
         rx_int_en_ff <= 1'b0;
      end else if (WR_IN) begin
         unique case (ADDR_IN)
            rx_err_pkg::ADDR_CTRL: ctrl_ff <= WDATA_IN;
            rx_err_pkg::ADDR_CTRL2: ctrl2_ff <= WDATA_IN;
            rx_err_pkg::ADDR_BAUD_LOW: baud_ff[7:0] <= WDATA_IN;
            rx_err_pkg::ADDR_BAUD_HIGH: baud_ff[15:8] <= WDATA_IN;
            rx_err_pkg::ADDR_ERR_IE: err_ie_ff <= WDATA_IN[3:0];
            rx_err_pkg::ADDR_INT: rx_int_en_ff <= WDATA_IN[rx_err_pkg::INT_RXE_BIT];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Receive shifter
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN || !run_w) begin
         state_ff <= rx_err_pkg::ST_IDLE;
         tick_ff <= 16'h0000;
         bit_ff <= 3'h0;
         shift_ff <= 8'h00;
         par_bit_ff <= 1'b0;
      end else begin
         tick_ff <= (end_w || state_ff == rx_err_pkg::ST_IDLE) ? 16'h0000 : tick_ff + 16'h0001;
         unique case (state_ff)
            rx_err_pkg::ST_IDLE: begin
               if (!line_w) begin
                  state_ff <= rx_err_pkg::ST_START;
               end
            end
            rx_err_pkg::ST_START: begin
               if (mid_w) begin
                  // False start bit goes back to idle
                  state_ff <= line_w ? rx_err_pkg::ST_IDLE : rx_err_pkg::ST_DATA;
                  bit_ff <= 3'h0;
                  // Restart the count here so every later sample falls at mid-bit
                  tick_ff <= 16'h0000;
               end
            end
            rx_err_pkg::ST_DATA: begin
               if (end_w) begin
                  shift_ff <= {line_w, shift_ff[7:1]};
                  bit_ff <= bit_ff + 3'h1;
                  if (bit_ff == 3'h7) begin
                     state_ff <= par_mode_w ? rx_err_pkg::ST_PARITY : rx_err_pkg::ST_STOP;
                  end
               end
            end
            rx_err_pkg::ST_PARITY: begin
               if (end_w) begin
                  par_bit_ff <= line_w;
                  state_ff <= rx_err_pkg::ST_STOP;
               end
            end
            rx_err_pkg::ST_STOP: begin
               // Sampled one bit on from the last mid point
               if (end_w) begin
                  state_ff <= rx_err_pkg::ST_IDLE; // see R3
               end
            end
            default: state_ff <= rx_err_pkg::ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // FIFO
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK_IN) begin
      if (push_w) begin
         mem_ff[wptr_ff] <= {par_mode_w && !par_ok_w, !line_w, shift_ff}; // see R1
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN || !on_w) begin // see R5 see R22
         wptr_ff <= '0;
         rptr_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push_w) begin
            wptr_ff <= wptr_ff + 1'b1;
         end
         if (pop_w) begin
            rptr_ff <= rptr_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + {1'b0, push_w} - {1'b0, pop_w};
      end
   end

   // ---------------------------------------------------------------
   // Flags; hardware set wins over a software clear
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin // see R22
         ovf_ff <= 1'b0;
      end else if (drop_w) begin
         ovf_ff <= 1'b1; // see R12 see R15
      end else if (WR_IN && ADDR_IN == rx_err_pkg::ADDR_ERR_FLAG &&
                   !WDATA_IN[rx_err_pkg::ERR_OVF_BIT]) begin
         ovf_ff <= 1'b0; // see R15
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN || !on_w) begin
         rxf_ff <= 1'b0;
      end else if (push_w) begin
         rxf_ff <= 1'b1; // see R17
      end else if (pop_w && cnt_ff == 2'h1) begin
         rxf_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Outputs and read port
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         RX_IRQ_OUT <= 1'b0;
         ERR_IRQ_OUT <= 1'b0;
      end else begin
         RX_IRQ_OUT <= rxf_ff && rx_int_en_ff && !frm_hide_w && !par_hide_w; // see R17
         ERR_IRQ_OUT <= frm_hide_w || par_hide_w || // see R6 see R10
                        (err_ie_ff[rx_err_pkg::ERR_OVF_BIT] && ovf_ff); // see R16
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         RDATA_OUT <= 8'h00;
      end else if (RD_IN) begin
         unique case (ADDR_IN)
            rx_err_pkg::ADDR_CTRL: RDATA_OUT <= ctrl_ff;
            rx_err_pkg::ADDR_CTRL2: RDATA_OUT <= ctrl2_ff;
            rx_err_pkg::ADDR_BAUD_LOW: RDATA_OUT <= baud_ff[7:0];
            rx_err_pkg::ADDR_BAUD_HIGH: RDATA_OUT <= baud_ff[15:8];
            rx_err_pkg::ADDR_ERR_FLAG: RDATA_OUT <= {4'h0, head_par_w, head_frm_w,
                                                     ovf_ff, 1'b0}; // see R2 see R9
            rx_err_pkg::ADDR_ERR_IE: RDATA_OUT <= {4'h0, err_ie_ff};
            rx_err_pkg::ADDR_RX_BUF: RDATA_OUT <= empty_w ? 8'h00 : head_w[7:0];
            rx_err_pkg::ADDR_INT: RDATA_OUT <= {5'h00, ERR_IRQ_OUT, rx_int_en_ff,
                                                rxf_ff && !frm_hide_w && !par_hide_w};
            default: RDATA_OUT <= 8'h00;
         endcase
      end else begin
         RDATA_OUT <= 8'h00;
      end
   end
endmodule : uart_rx_error_fifo
`default_nettype wire

// ===== bench/uart_line_driver.sv
// Remote serial transmitter: one 11-bit frame, first bit first, then an idle bit.
// Assumes the bench holds frame_in and inv_in steady while busy_out is high.
`timescale 1ns/1ps
`default_nettype none
module uart_line_driver #(parameter int BIT_CLKS = 8) (
   input wire logic clk_in,
   input wire logic go_in,
   input wire logic [10:0] frame_in,
   input wire logic inv_in,
   output logic line_out,
   output logic busy_out
);
   logic [11:0] sh_ff = 12'hFFF;
   int cnt_ff = 0;
   int idx_ff = 12;
   // A missing stop is cut short so its tail cannot pass for a start
   wire logic cut = idx_ff == 10 && cnt_ff >= BIT_CLKS * 3 / 4;
   assign line_out = (sh_ff[0] | cut) ^ inv_in;
   assign busy_out = idx_ff < 12;
   always_ff @(posedge clk_in) begin
      if (go_in && idx_ff == 12) begin
         sh_ff <= {1'b1, frame_in};
         idx_ff <= 0;
         cnt_ff <= 0;
      end else if (idx_ff < 12) begin
         cnt_ff <= (cnt_ff == BIT_CLKS - 1) ? 0 : cnt_ff + 1;
         if (cnt_ff == BIT_CLKS - 1) begin
            sh_ff <= {1'b1, sh_ff[11:1]};
            idx_ff <= idx_ff + 1;
         end
      end
   end
endmodule : uart_line_driver
`default_nettype wire

// ===== bench/uart_rx_error_fifo_props.sv
// Port-level checker for the receive channel.
// Assumes it is bound into the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_error_fifo_props (
   input wire logic CORE_CLK_IN,
   input wire logic RST_IN,
   input wire logic [3:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic [7:0] RDATA_OUT,
   input wire logic RX_IRQ_OUT,
   input wire logic ERR_IRQ_OUT
);
   // ---------------------------------------------------------------
   // Shadow of the enable bits
   // ---------------------------------------------------------------
   logic [3:1] ie_ff;
   logic rxe_ff;
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) ie_ff <= 3'h0;
      else if (WR_IN && ADDR_IN == rx_err_pkg::ADDR_ERR_IE) ie_ff <= WDATA_IN[3:1];
   end
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) rxe_ff <= 1'b0;
      else if (WR_IN && ADDR_IN == rx_err_pkg::ADDR_INT) rxe_ff <= WDATA_IN[1];
   end
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (RST_IN);
   // Read data and interrupt lines both reflect state before the read edge
   sequence s_rd(logic [3:0] a);
      RD_IN && ADDR_IN == a ##1 1'b1;
   endsequence
   property p_reset; $fell(RST_IN) |-> !ERR_IRQ_OUT && !RX_IRQ_OUT; endproperty
   property p_idle; !$past(RD_IN) |-> RDATA_OUT == 8'h00; endproperty
   property p_unmap; RD_IN && ADDR_IN[3] |=> RDATA_OUT == 8'h00; endproperty
   property p_ieback; s_rd(rx_err_pkg::ADDR_ERR_IE) |-> RDATA_OUT[3:1] == ie_ff; endproperty
   property p_summary;
      s_rd(rx_err_pkg::ADDR_ERR_FLAG) |-> ERR_IRQ_OUT == |(RDATA_OUT[3:1] & ie_ff);
   endproperty
   property p_suppress;
      s_rd(rx_err_pkg::ADDR_ERR_FLAG) ##0 |(RDATA_OUT[3:2] & ie_ff[3:2]) |-> !RX_IRQ_OUT;
   endproperty
   property p_intrd;
      s_rd(rx_err_pkg::ADDR_INT) |-> RDATA_OUT[1] == rxe_ff && (!RX_IRQ_OUT || RDATA_OUT[0]);
   endproperty
   property p_rxeoff;
      WR_IN && ADDR_IN == rx_err_pkg::ADDR_INT && !WDATA_IN[1] |-> ##[1:3] !RX_IRQ_OUT;
   endproperty
   a_reset: assert property (p_reset) else $error("irq high after reset");
   a_idle: assert property (p_idle) else $error("read data without read");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_ieback: assert property (p_ieback) else $error("enable readback");
   a_summary: assert property (p_summary) else $error("summary error wrong");
   a_suppress: assert property (p_suppress) else $error("receive irq not hidden");
   a_intrd: assert property (p_intrd) else $error("int register wrong");
   a_rxeoff: assert property (p_rxeoff) else $error("receive irq stays");
endmodule : uart_rx_error_fifo_props
bind uart_rx_error_fifo uart_rx_error_fifo_props u_props (.CORE_CLK_IN(CORE_CLK_IN),
   .RST_IN(RST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
   .RDATA_OUT(RDATA_OUT), .RX_IRQ_OUT(RX_IRQ_OUT), .ERR_IRQ_OUT(ERR_IRQ_OUT));
`default_nettype wire

// ===== bench/uart_rx_error_fifo_tb.sv
// Self-checking bench: random characters, error tags, overflow and port-off.
// Assumes bit time of eight clocks (divisor 7) and all error enables set.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_error_fifo_tb;
   logic clk, rst, wr, rd, go, inv, line, busy, rx_irq, err_irq, odd;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, got;
   logic [10:0] frame;
   logic [7:0] dq[2];
   logic pq[2], fq[2];
   int n_mismatch = 0;
   int samples_checked = 0;
   int seed;
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   uart_rx_error_fifo u_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .RX_LINE_IN(line), .ADDR_IN(addr),
      .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .RX_IRQ_OUT(rx_irq),
      .ERR_IRQ_OUT(err_irq));
   uart_line_driver #(.BIT_CLKS(8)) u_far (.clk_in(clk), .go_in(go), .frame_in(frame),
      .inv_in(inv), .line_out(line), .busy_out(busy));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic conclude();
      if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk8
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 got = rdata;
   endtask : rreg
   task automatic send(input logic [7:0] d, input logic pe, input logic fe);
      @(posedge clk);
      frame <= {~fe, ^d ^ odd ^ pe, d, 1'b0};
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (int i = 0; i < 300 && (i < 2 || busy); i++) @(negedge clk);
   endtask : send
   function automatic logic [7:0] flags(input logic o, input logic f, input logic p);
      return {4'h0, p, f, o, 1'b0};
   endfunction : flags
   // Error flags first, then the byte, as software must
   // An empty FIFO (v low) leaves the receive flag clear
   task automatic head(input logic [7:0] d, input logic p, input logic f, input logic o,
                       input logic v = 1'b1);
      rreg(rx_err_pkg::ADDR_ERR_FLAG);
      chk8(got & 8'h0E, flags(o, f, p));
      chk8({6'h0, err_irq, rx_irq}, {6'h0, p | f | o, v & !(p | f)});
      rreg(rx_err_pkg::ADDR_RX_BUF);
      chk8(got, d);
   endtask : head
   initial begin
      #100000;
      n_mismatch++;
      conclude();
   end
   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      {rst, wr, rd, go, inv, odd, addr, wdata, frame} = {1'b1, 5'h00, 4'h0, 8'h00, 11'h7FF};
      seed = $urandom(43564);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rreg(rx_err_pkg::ADDR_CTRL);
      chk8(got, rx_err_pkg::CTRL_RESET);
      rreg(rx_err_pkg::ADDR_RX_BUF);
      chk8(got, 8'h00);
      wreg(rx_err_pkg::ADDR_BAUD_LOW, 8'h07);
      wreg(rx_err_pkg::ADDR_BAUD_HIGH, 8'h00);
      wreg(rx_err_pkg::ADDR_ERR_IE, 8'h0E);
      wreg(rx_err_pkg::ADDR_INT, 8'h02);
      for (int c = 0; c < 4; c++) begin
         odd = c[0];
         wreg(rx_err_pkg::ADDR_CTRL, 8'h00);
         inv <= c[1];
         wreg(rx_err_pkg::ADDR_CTRL2, {5'h0, c[1], 2'h0});
         wreg(rx_err_pkg::ADDR_CTRL, odd ? 8'h82 : 8'h83);
         wreg(rx_err_pkg::ADDR_CTRL, odd ? 8'h92 : 8'h93);
         for (int k = 0; k < 2; k++) begin
            {dq[k], pq[k], fq[k]} = 10'($urandom);
            if (c == 0 && k == 0) {pq[k], fq[k]} = 2'b11;
            send(dq[k], pq[k], fq[k]);
         end
         for (int k = 0; k < 2; k++) head(dq[k], pq[k], fq[k], 1'b0);
         head(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
         rreg(rx_err_pkg::ADDR_ERR_IE);
         chk8(got, 8'h0E);
      end
      for (int r = 1; r >= 0; r--) begin
         wreg(rx_err_pkg::ADDR_CTRL2, {r[0], 4'h0, 1'b1, 2'h0});
         send(8'hA5, 1'b0, 1'b0);
         send(8'h5A, 1'b0, 1'b0);
         send(8'hC3, 1'b0, 1'b0);
         if (r == 1) wreg(rx_err_pkg::ADDR_ERR_FLAG, 8'h00);
         if (r == 1) send(8'h3C, 1'b0, 1'b0);
         head(8'hA5, 1'b0, 1'b0, 1'b1);
         wreg(rx_err_pkg::ADDR_ERR_FLAG, 8'h00);
         send(8'h96, 1'b0, 1'b0);
         head(8'h5A, 1'b0, 1'b0, 1'b0);
         head(8'h96, 1'b0, 1'b0, 1'b0);
      end
      send(8'h11, 1'b0, 1'b1);
      wreg(rx_err_pkg::ADDR_ERR_FLAG, 8'hFF);
      rreg(rx_err_pkg::ADDR_ERR_FLAG);
      chk8(got & 8'h0E, flags(1'b0, 1'b1, 1'b0));
      wreg(rx_err_pkg::ADDR_ERR_IE, 8'h00);
      wreg(rx_err_pkg::ADDR_INT, 8'h00);
      rreg(rx_err_pkg::ADDR_INT);
      chk8({got[1:0], err_irq, rx_irq}, 4'h4);
      wreg(rx_err_pkg::ADDR_CTRL, 8'h00);
      rreg(rx_err_pkg::ADDR_ERR_FLAG);
      chk8(got & 8'h0E, 8'h00);
      for (int a = 8; a < 16; a++) begin
         rreg(4'(a));
         chk8(got, 8'h00);
      end
      conclude();
   end
endmodule : uart_rx_error_fifo_tb
`default_nettype wire
